// [logic/cabe_exec.sv]
// Purpose: Executes arithmetic, logic, compare, skip and branch instructions
// Assumes: Operands fetched by the caller; io_val is the addressed I/O register
// Notes:   A taken skip or branch holds the core one extra cycle (busy)

// Function
// - Add source to destination, optional carry, write sum, five flags, one cycle
// - Subtract immediate from destination, store it, five flags, one cycle
// - Subtract source, optional carry, from destination, five flags, one cycle
// - Subtract immediate and carry from destination, five flags, one cycle
// - AND destination with immediate, update Z N V S only, one cycle
// - OR destination with immediate, write back, update Z N V, one cycle
// - Set masked destination bits by OR, update Z N V, one cycle
// - Clear masked bits by AND with FFh minus mask, Z N V, one cycle
// - Test register by ANDing with itself, value kept, Z N V, one cycle
// - Skip next on register equality, no flags, one or two cycles
// - Register minus immediate, result discarded, five flags, one cycle
// - Skip next when register bit is zero, no flags, one or two cycles
// - Skip next when register bit is one, no flags, one or two cycles
// - Skip next when I/O register bit is zero, no flags, one/two cycles
// - Skip next when I/O register bit is one, no flags, one/two cycles
// - Branch PC+k+1 when status bit set, no flags, one or two cycles
// - Branch PC+k+1 when status bit clear, no flags, one or two cycles
// - Branch when N xor V is zero, one cycle untaken, two taken
module cabe_exec (
	input  wire logic                core_clk,  // Core clock
	input  wire logic                rst,       // Sync reset, active high
	input  wire cabe_pkg::cabe_instr_t instr,   // Decoded instruction
	input  wire logic                instr_valid, // Instruction present
	input  wire logic [7:0]          io_val,    // Addressed I/O register value
	output logic                     instr_ready, // Accepts an instruction
	output cabe_pkg::cabe_wb_t       wb,        // Register file write
	output logic [15:0]              pc,        // Program counter
	output logic [7:0]               sreg,      // Status register
	output logic                     busy       // Second cycle of taken flow
);
	typedef enum logic [0:0] {ST_RUN, ST_HOLD} cabe_state_t;

	cabe_state_t state_reg;
	logic [15:0] pc_reg;
	logic [15:0] pc_next;
	logic [7:0]  sreg_reg;
	logic [7:0]  sreg_next;
	logic [7:0]  res;
	logic        res_we;
	logic        flow;
	logic        fire;

	// Result plus H, V, C for add (sub_n=0) or subtract (sub_n=1)
	function automatic logic [10:0] arith(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic sub_n);
		logic [8:0] r;
		logic       h;
		logic       v;
		logic       c;
		if (!sub_n) begin
			r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
			v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
			c = r[8];
		end else begin
			r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
			v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
			c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		end
		return {h, v, c, r[7:0]};
	endfunction

	// Status after arithmetic: all five plus sign
	function automatic logic [7:0] flags5(input logic [7:0] s, input logic [10:0] x,
		input logic keep_z);
		logic [7:0] o;
		o = s;
		o[cabe_pkg::SR_H] = x[10];
		o[cabe_pkg::SR_V] = x[9];
		o[cabe_pkg::SR_C] = x[8];
		o[cabe_pkg::SR_N] = x[7];
		o[cabe_pkg::SR_Z] = (x[7:0] == 8'h00) & (keep_z ? s[cabe_pkg::SR_Z] : 1'b1);
		o[cabe_pkg::SR_S] = x[7] ^ x[9];
		return o;
	endfunction

	// Status after logic ops: Z N V, V cleared
	function automatic logic [7:0] flags3(input logic [7:0] s, input logic [7:0] r);
		logic [7:0] o;
		o = s;
		o[cabe_pkg::SR_V] = 1'b0;
		o[cabe_pkg::SR_N] = r[7];
		o[cabe_pkg::SR_Z] = (r == 8'h00);
		o[cabe_pkg::SR_S] = r[7];
		return o;
	endfunction

	logic [10:0] ax;
	logic [7:0]  ra;
	logic [7:0]  rb;
	logic        skip;
	logic        take;
	logic [15:0] rel;

	assign fire        = instr_valid && instr_ready;
	assign instr_ready = (state_reg == ST_RUN);
	assign busy        = (state_reg == ST_HOLD);
	assign rel         = {{(16 - cabe_pkg::OFS_W){instr.offset[6]}}, instr.offset};

	always_comb begin
		ra        = instr.rd_val;
		rb        = instr.rr_val;
		res       = 8'h00;
		res_we    = 1'b0;
		skip      = 1'b0;
		take      = 1'b0;
		ax        = 11'h000;
		sreg_next = sreg_reg;
		case (instr.op)
			cabe_pkg::OP_ADD, cabe_pkg::OP_ADD_CARRY: begin
				ax = arith(ra, rb, (instr.op == cabe_pkg::OP_ADD_CARRY) &
					sreg_reg[cabe_pkg::SR_C], 1'b0);
				res = ax[7:0];
				res_we = 1'b1;
				sreg_next = flags5(sreg_reg, ax, 1'b0);
			end
			// Register subtract, borrow variant chains Z
			cabe_pkg::OP_MINUS_REGS, cabe_pkg::OP_MINUS_REGS_BORROW: begin
				ax = arith(ra, rb, (instr.op == cabe_pkg::OP_MINUS_REGS_BORROW) &
					sreg_reg[cabe_pkg::SR_C], 1'b1);
				res = ax[7:0];
				res_we = 1'b1;
				sreg_next = flags5(sreg_reg, ax, instr.op == cabe_pkg::OP_MINUS_REGS_BORROW);
			end
			cabe_pkg::OP_MINUS_CONST: begin
				ax = arith(ra, instr.imm, 1'b0, 1'b1);
				res = ax[7:0];
				res_we = 1'b1;
				sreg_next = flags5(sreg_reg, ax, 1'b0);
			end
			cabe_pkg::OP_MINUS_CONST_BORROW: begin
				ax = arith(ra, instr.imm, sreg_reg[cabe_pkg::SR_C], 1'b1);
				res = ax[7:0];
				res_we = 1'b1;
				sreg_next = flags5(sreg_reg, ax, 1'b1);
			end
			cabe_pkg::OP_COMPARE_CONST: begin
				ax = arith(ra, instr.imm, 1'b0, 1'b1);
				sreg_next = flags5(sreg_reg, ax, 1'b0);
			end
			cabe_pkg::OP_MASK_CONST_CONJ: begin
				res = ra & instr.imm;
				res_we = 1'b1;
				sreg_next = flags3(sreg_reg, res);
			end
			cabe_pkg::OP_MERGE_CONST_DISJ, cabe_pkg::OP_SET_MASK_BITS: begin
				res = ra | instr.imm;
				res_we = 1'b1;
				sreg_next = flags3(sreg_reg, res);
			end
			cabe_pkg::OP_CLEAR_MASK_BITS: begin
				res = ra & (cabe_pkg::ALL_ONES - instr.imm);
				res_we = 1'b1;
				sreg_next = flags3(sreg_reg, res);
			end
			cabe_pkg::OP_SELF_TEST_FLAGS: begin
				res = ra & ra;
				res_we = 1'b1;
				sreg_next = flags3(sreg_reg, res);
			end
			cabe_pkg::OP_EQUAL_SKIP:        skip = (ra == rb);
			cabe_pkg::OP_SKIP_REG_BIT_LOW:  skip = ~rb[instr.bit_sel];
			cabe_pkg::OP_SKIP_REG_BIT_HIGH: skip = rb[instr.bit_sel];
			cabe_pkg::OP_SKIP_IO_BIT_LOW:   skip = ~io_val[instr.bit_sel];
			cabe_pkg::OP_SKIP_IO_BIT_HIGH:  skip = io_val[instr.bit_sel];
			cabe_pkg::OP_JUMP_ON_FLAG_HIGH: take = sreg_reg[instr.bit_sel];
			cabe_pkg::OP_JUMP_ON_FLAG_LOW:  take = ~sreg_reg[instr.bit_sel];
			cabe_pkg::OP_JUMP_SIGNED_GE:
				take = ~(sreg_reg[cabe_pkg::SR_N] ^ sreg_reg[cabe_pkg::SR_V]);
			default: begin
				res = 8'h00;
			end
		endcase
	end

	assign flow = fire && (skip || take);

	always_comb begin
		pc_next = pc_reg;
		if (fire) begin
			if (take)
				pc_next = pc_reg + rel + cabe_pkg::PC_STEP;
			else if (skip)
				pc_next = pc_reg + (instr.next_two_word ? cabe_pkg::SKIP_TWO_WORD :
					cabe_pkg::SKIP_ONE_WORD);
			else
				pc_next = pc_reg + cabe_pkg::PC_STEP;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			pc_reg <= cabe_pkg::PC_RESET;
		else
			pc_reg <= pc_next;
	end

	// Flags change only on accepted instructions
	always_ff @(posedge core_clk) begin
		if (rst)
			sreg_reg <= cabe_pkg::SREG_RESET;
		else if (fire)
			sreg_reg <= sreg_next;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wb.we   <= 1'b0;
			wb.data <= 8'h00;
		end else begin
			wb.we   <= fire && res_we;
			wb.data <= res;
		end
	end

	// Taken flow costs one extra cycle
	always_ff @(posedge core_clk) begin
		if (rst)
			state_reg <= ST_RUN;
		else begin
			case (state_reg)
				ST_RUN:  state_reg <= flow ? ST_HOLD : ST_RUN;
				ST_HOLD: state_reg <= ST_RUN;
				default: state_reg <= ST_RUN;
			endcase
		end
	end

	assign pc   = pc_reg;
	assign sreg = sreg_reg;

	sequence s_add_go;
		fire && instr.op == cabe_pkg::OP_ADD;
	endsequence
	sequence s_flow_go;
		flow;
	endsequence

	a_add_result: assert property (@(posedge core_clk) disable iff (rst)
		s_add_go |=> wb.we && wb.data == 8'($past(instr.rd_val) + $past(instr.rr_val)))
		else $error("add result wrong");
	a_minus_const: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_MINUS_CONST |=>
		wb.data == 8'($past(instr.rd_val) - $past(instr.imm)))
		else $error("immediate subtract wrong");
	a_and_carry_kept: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_MASK_CONST_CONJ |=>
		$stable(sreg[cabe_pkg::SR_C]) && $stable(sreg[cabe_pkg::SR_H]) && !sreg[cabe_pkg::SR_V])
		else $error("logic op touched carry");
	a_clear_mask: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_CLEAR_MASK_BITS |=>
		(wb.data & $past(instr.imm)) == 8'h00)
		else $error("mask bits not cleared");
	a_compare_nowrite: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_COMPARE_CONST |=> !wb.we &&
		sreg[cabe_pkg::SR_Z] == ($past(instr.rd_val) == $past(instr.imm)))
		else $error("compare wrote result");
	a_flow_two_cycle: assert property (@(posedge core_clk) disable iff (rst)
		s_flow_go |=> busy && !instr_ready ##1 instr_ready)
		else $error("taken flow not two cycles");
	a_skip_flags_kept: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_SKIP_REG_BIT_LOW |=> $stable(sreg))
		else $error("skip changed flags");
	a_branch_target: assert property (@(posedge core_clk) disable iff (rst)
		fire && take |=> pc == 16'($past(pc) + {{9{$past(instr.offset[6])}},
		$past(instr.offset)} + 16'h0001))
		else $error("branch target wrong");
	a_skip_distance: assert property (@(posedge core_clk) disable iff (rst)
		fire && skip |=> pc == 16'($past(pc) + ($past(instr.next_two_word) ? 16'h0003 :
		16'h0002)))
		else $error("skip distance wrong");
	a_add_carry: assert property (@(posedge core_clk) disable iff (rst)
		s_add_go |=> sreg[cabe_pkg::SR_C] ==
		((9'($past(instr.rd_val)) + 9'($past(instr.rr_val))) > 9'h0ff))
		else $error("add carry wrong");
	a_minus_regs: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_MINUS_REGS_BORROW |=> wb.we &&
		wb.data == 8'($past(instr.rd_val) - $past(instr.rr_val) -
		8'($past(sreg[cabe_pkg::SR_C]))))
		else $error("borrow subtract wrong");
	a_const_borrow: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_MINUS_CONST_BORROW |=> wb.we &&
		wb.data == 8'($past(instr.rd_val) - $past(instr.imm) -
		8'($past(sreg[cabe_pkg::SR_C]))))
		else $error("immediate borrow subtract wrong");
	a_or_result: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_MERGE_CONST_DISJ |=> wb.we &&
		wb.data == ($past(instr.rd_val) | $past(instr.imm)) && !sreg[cabe_pkg::SR_V])
		else $error("or result wrong");
	a_set_mask: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_SET_MASK_BITS |=> wb.we &&
		(wb.data & $past(instr.imm)) == $past(instr.imm))
		else $error("mask bits not set");
	a_test_keeps: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_SELF_TEST_FLAGS |=>
		wb.data == $past(instr.rd_val) && sreg[cabe_pkg::SR_Z] == (wb.data == 8'h00) &&
		sreg[cabe_pkg::SR_N] == wb.data[7])
		else $error("test changed value or flags");
	a_equal_skip: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_EQUAL_SKIP |=>
		busy == ($past(instr.rd_val) == $past(instr.rr_val)) && $stable(sreg))
		else $error("equal skip wrong");
	a_skip_high_reg: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_SKIP_REG_BIT_HIGH |=>
		busy == $past(instr.rr_val[instr.bit_sel]) && $stable(sreg))
		else $error("register bit skip wrong");
	a_skip_low_io: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_SKIP_IO_BIT_LOW |=>
		busy == !$past(io_val[instr.bit_sel]) && $stable(sreg))
		else $error("io bit low skip wrong");
	a_skip_high_io: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_SKIP_IO_BIT_HIGH |=>
		busy == $past(io_val[instr.bit_sel]) && $stable(sreg))
		else $error("io bit high skip wrong");
	a_jump_flag_low: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_JUMP_ON_FLAG_LOW |=>
		busy == !$past(sreg[instr.bit_sel]) && $stable(sreg))
		else $error("flag low branch wrong");
	a_jump_signed_ge: assert property (@(posedge core_clk) disable iff (rst)
		fire && instr.op == cabe_pkg::OP_JUMP_SIGNED_GE |=>
		busy == ($past(sreg[cabe_pkg::SR_N]) == $past(sreg[cabe_pkg::SR_V])) && $stable(sreg))
		else $error("signed branch wrong");
endmodule

// [shared/cabe_pkg.sv]
// Purpose: Shared constants and types for the ALU and branch execution block
// Assumes: 8-bit data path, 16-bit instruction words, 25 MHz core clock
// Notes:   Status bit positions follow the usual I T H S V N Z C order
package cabe_pkg;
	localparam int DATA_W  = 8;
	localparam int PC_W    = 16;
	localparam int OFS_W   = 7;

	// Status register bit positions
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 3;
	localparam int SR_S = 4;
	localparam int SR_H = 5;

	// Reset values and the all-ones mask
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [7:0]  SREG_RESET = 8'h00;
	localparam logic [7:0]  ALL_ONES   = 8'hff;

	// Cycle counts
	localparam int CYC_PLAIN = 1;
	localparam int CYC_TAKEN = 2;

	// Skip distances in words
	localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
	localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;
	localparam logic [15:0] PC_STEP       = 16'h0001;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_ADD,
		OP_ADD_CARRY,
		OP_MINUS_REGS,
		OP_MINUS_CONST,
		OP_MINUS_REGS_BORROW,
		OP_MINUS_CONST_BORROW,
		OP_MASK_CONST_CONJ,
		OP_MERGE_CONST_DISJ,
		OP_SET_MASK_BITS,
		OP_CLEAR_MASK_BITS,
		OP_SELF_TEST_FLAGS,
		OP_EQUAL_SKIP,
		OP_COMPARE_CONST,
		OP_SKIP_REG_BIT_LOW,
		OP_SKIP_REG_BIT_HIGH,
		OP_SKIP_IO_BIT_LOW,
		OP_SKIP_IO_BIT_HIGH,
		OP_JUMP_ON_FLAG_HIGH,
		OP_JUMP_ON_FLAG_LOW,
		OP_JUMP_SIGNED_GE
	} cabe_op_t;

	// Decoded instruction presented to the execution unit
	typedef struct packed {
		cabe_op_t          op;
		logic [7:0]        rd_val;
		logic [7:0]        rr_val;
		logic [7:0]        imm;
		logic [2:0]        bit_sel;
		logic [6:0]        offset;
		logic              next_two_word;
	} cabe_instr_t;

	// Result write to the working register file
	typedef struct packed {
		logic       we;
		logic [7:0] data;
	} cabe_wb_t;
endpackage

// [test/cabe_io_model.sv]
// Purpose: Far-side model of the addressed I/O register
// Assumes: Register content is set by the bench
// Notes:   Outside a valid instruction the bus shows a pattern that flips each cycle
module cabe_io_model (
	input  wire logic       core_clk,    // Core clock
	input  wire logic       instr_valid, // Instruction present
	input  wire logic [7:0] io_reg,      // Register content
	output logic      [7:0] io_val       // Value seen by the core
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] junk = 8'h00;
	// Idle bus must never look like the register
	always @(posedge core_clk)
		junk <= ~junk;
	assign io_val = instr_valid ? io_reg : junk;
endmodule

// [test/tb_top.sv]
// Purpose: Self-checking bench for the ALU and branch execution block
// Assumes: Inputs change on the falling edge, outputs checked one cycle later
// Notes:   Flags and PC are predicted here from operands, never read back
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  core_clk    = 1'b0;
	logic                  rst         = 1'b1;
	logic                  instr_valid = 1'b0;
	logic [7:0]            io_reg      = 8'h5a;
	logic [7:0]            io_val;
	logic                  instr_ready;
	logic                  busy;
	logic [15:0]           pc;
	logic [7:0]            sreg;
	cabe_pkg::cabe_wb_t    wb;
	cabe_pkg::cabe_instr_t instr       = '0;
	logic [7:0]            sr          = 8'h00;
	logic [7:0]            res;
	logic [15:0]           epc         = 16'h0000;
	int                    n_errors    = 0;
	int                    checked     = 0;
	int                    cyc         = 0;

	always #20 core_clk = ~core_clk;

	cabe_exec cabe_exec_inst (.core_clk, .rst, .instr, .instr_valid, .io_val,
		.instr_ready, .wb, .pc, .sreg, .busy);
	cabe_io_model cabe_io_model_inst (.core_clk, .instr_valid, .io_reg, .io_val);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Carry-in only as the caller decides; chain keeps Z only if Z was set
	function automatic logic [7:0] arith(input logic [7:0] a, b, input logic c, sub, chain);
		logic [8:0] r;
		logic [4:0] h;
		logic       v;
		r   = sub ? {1'b0, a} - b - c : {1'b0, a} + b + c;
		h   = sub ? {1'b0, a[3:0]} - b[3:0] - c : {1'b0, a[3:0]} + b[3:0] + c;
		v   = (a[7] ^ b[7] ^ !sub) & (r[7] ^ a[7]);
		res = r[7:0];
		return {sr[7:5] & 3'b110 | {2'b00, h[4]}, r[7] ^ v, v, r[7],
			(r[7:0] == 8'h00) & (!chain | sr[1]), r[8]};
	endfunction

	function automatic logic [7:0] lg(input logic [7:0] r);
		return {sr[7:5], r[7], 1'b0, r[7], r == 8'h00, sr[0]};
	endfunction

	task automatic run(input cabe_pkg::cabe_instr_t i, input logic ew, input logic [7:0] ed,
			input logic [15:0] dpc, input logic hold);
		@(negedge core_clk);
		instr       = i;
		instr_valid = 1'b1;
		@(negedge core_clk);
		instr_valid = 1'b0;
		epc         = epc + dpc;
		chk("wb.we", ew, wb.we);
		if (ew)
			chk("wb.data", ed, wb.data);
		chk("pc", epc, pc);
		chk("sreg", sr, sreg);
		chk("busy", hold, busy);
		chk("instr_ready", !hold, instr_ready);
		if (hold) begin
			@(negedge core_clk);
			chk("instr_ready", 1'b1, instr_ready);
		end
	endtask

	task automatic t_arith;
		logic [7:0]            ta [4] = '{8'hff, 8'h7f, 8'h00, 8'h80};
		logic [7:0]            tb [4] = '{8'h01, 8'h01, 8'h01, 8'h80};
		logic                  cb, kc;
		cabe_pkg::cabe_instr_t i;
		for (int op = 1; op <= 13; op++) begin
			if (op > 6 && op < 13)
				continue;
			for (int p = 0; p < 4; p++) begin
				cb = (op == 2 || op == 5 || op == 6) & sr[0];
				kc = op == 4 || op == 6 || op == 13;
				sr = arith(ta[p], tb[p], cb, op > 2, op == 5 || op == 6);
				i  = '{cabe_pkg::cabe_op_t'(op), ta[p], kc ? ~tb[p] : tb[p],
					kc ? tb[p] : ~tb[p], 3'h0, 7'h00, 1'b0};
				run(i, op != 13, res, 16'h0001, 1'b0);
			end
		end
	endtask

	task automatic t_logic;
		logic [7:0] r;
		sr = arith(8'hff, 8'hff, 1'b0, 1'b0, 1'b0);
		run('{cabe_pkg::OP_ADD, 8'hff, 8'hff, 8'h00, 3'h0, 7'h00, 1'b0}, 1'b1, res, 16'h0001, 1'b0);
		for (int op = 7; op <= 11; op++) begin
			case (op)
				7: r = 8'h96 & 8'h69;
				8, 9: r = 8'h96 | 8'h69;
				10: r = 8'h96 & (8'hff - 8'h69);
				default: r = 8'h96;
			endcase
			sr = lg(r);
			run('{cabe_pkg::cabe_op_t'(op), 8'h96, 8'h0f, 8'h69, 3'h0, 7'h00, 1'b0},
				1'b1, r, 16'h0001, 1'b0);
		end
		// No operation only steps the counter
		run('{cabe_pkg::OP_NOP, 8'h96, 8'h0f, 8'h69, 3'h0, 7'h00, 1'b1}, 1'b0, 8'h00, 16'h0001,
			1'b0);
	endtask

	task automatic t_skip;
		logic tk;
		for (int op = 14; op <= 17; op++)
			for (int k = 0; k < 4; k++) begin
				tk = io_reg[k] ^ !op[0];
				run('{cabe_pkg::cabe_op_t'(op), 8'h00, op > 15 ? 8'ha5 : 8'h5a, 8'h00, k[2:0],
					7'h00, k > 1}, 1'b0, 8'h00, tk ? (k > 1 ? 16'h0003 : 16'h0002) : 16'h0001,
					tk);
			end
		run('{cabe_pkg::OP_EQUAL_SKIP, 8'h3c, 8'h3c, 8'hc3, 3'h0, 7'h00, 1'b1}, 1'b0, 8'h00,
			16'h0003, 1'b1);
		run('{cabe_pkg::OP_EQUAL_SKIP, 8'h3c, 8'h3d, 8'h3c, 3'h0, 7'h00, 1'b0}, 1'b0, 8'h00,
			16'h0001, 1'b0);
	endtask

	task automatic t_branch;
		logic        tk;
		logic [15:0] d;
		logic [7:0]  a;
		for (int s = 0; s < 16; s++) begin
			tk = sr[s[2:0]] ^ s[3];
			d  = {{9{s[0]}}, s[0] ? 7'h40 : 7'h3f} + 16'h0001;
			run('{s[3] ? cabe_pkg::OP_JUMP_ON_FLAG_LOW : cabe_pkg::OP_JUMP_ON_FLAG_HIGH, 8'h00,
				8'h00, 8'h00, s[2:0], s[0] ? 7'h40 : 7'h3f, 1'b0}, 1'b0, 8'h00,
				tk ? d : 16'h0001, tk);
		end
		for (int p = 0; p < 3; p++) begin
			a  = p == 0 ? 8'h80 : (p == 1 ? 8'h00 : 8'h05);
			sr = arith(a, 8'h01, 1'b0, 1'b1, 1'b0);
			run('{cabe_pkg::OP_COMPARE_CONST, a, 8'h00, 8'h01, 3'h0, 7'h00, 1'b0}, 1'b0, 8'h00,
				16'h0001, 1'b0);
			tk = !(sr[2] ^ sr[3]);
			run('{cabe_pkg::OP_JUMP_SIGNED_GE, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0}, 1'b0,
				8'h00, tk ? 16'h0006 : 16'h0001, tk);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard, far above the fewer than two hundred cycles the tests need
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			conclude;
		end
	end

	initial begin
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		chk("pc", 16'h0000, pc);
		chk("sreg", 8'h00, sreg);
		chk("instr_ready", 1'b1, instr_ready);
		t_arith;
		$display("test arith finished");
		t_logic;
		$display("test logic finished");
		t_skip;
		$display("test skip finished");
		t_branch;
		$display("test branch finished");
		conclude;
	end
endmodule
